// file: verilog/sifd_pkg.sv
// Constants for the slave ID fault detector: register indices, codes, fields and timing
package sifd_pkg;
   // Register indices; the APB byte address is four times the index
   localparam logic [13:0] IDX_ALARM_CNT = 14'h2700;
   localparam logic [13:0] IDX_LIST_FIRST = 14'h2701;
   localparam logic [13:0] IDX_LIST_LAST = 14'h2780;
   localparam logic [13:0] IDX_FAULT_CODE = 14'h2810;
   localparam logic [13:0] IDX_FAULT_ID = 14'h2811;
   localparam logic [13:0] IDX_CTRL = 14'h2820;
   localparam logic [13:0] IDX_STATUS = 14'h2821;
   localparam logic [13:0] IDX_PAR_CMD = 14'h2822;
   localparam logic [13:0] IDX_PAR_SET = 14'h2850;
   localparam logic [13:0] IDX_PAR_TGT = 14'h2851;
   localparam int LIST_DEPTH = 128;
   localparam logic [7:0] LIST_FULL = 8'h80;
   // Fault codes and factory default identifiers
   localparam logic [15:0] FC_NONE = 16'h0000;
   localparam logic [15:0] FC_DUP = 16'h0190;
   localparam logic [15:0] FC_UNSET = 16'h0191;
   localparam logic [9:0] DEF_IN_ID = 10'h2FF;
   localparam logic [9:0] DEF_OUT_ID = 10'h0FF;
   // Control register fields
   localparam int CTRL_CLR_BIT = 0;
   localparam int CTRL_DET_BIT = 1;
   localparam int CTRL_AUTO_BIT = 2;
   localparam int CTRL_RATE_LSB = 4;
   localparam logic [3:0] RATE_RST = 4'h0;
   // Status register fields
   localparam int STAT_DET_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_ALARM_BIT = 2;
   localparam int STAT_DONE_BIT = 3;
   // Parameter command register fields
   localparam int PCMD_ACC_BIT = 0;
   localparam int PCMD_BRD_BIT = 1;
   localparam int PCMD_BWR_BIT = 2;
   // Parameter operations presented to the link
   localparam logic [1:0] OP_ACC_RD = 2'h0;
   localparam logic [1:0] OP_ACC_WR = 2'h1;
   localparam logic [1:0] OP_BAT_RD = 2'h2;
   localparam logic [1:0] OP_BAT_WR = 2'h3;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int AUTO_UPD_US = 1000;
   localparam int AUTO_UPD_CYC = AUTO_UPD_US * (CLK_HZ / 1_000_000);
   typedef enum logic [1:0] {DET_IDLE = 2'b01, DET_SCAN = 2'b10} sifd_det_t;
   typedef enum logic [1:0] {PAR_IDLE = 2'b01, PAR_BUSY = 2'b10} sifd_par_t;
endpackage

// file: verilog/sifd_top.sv
// Slave ID fault detector with APB register access and parameter transfer sequencing
//
// Contract
// - Detection checks all slaves for shared IDs
// - No duplicate report after power loss/reset
// - Each faulty ID listed once only
// - Duplicate sets alarm, code 0190, latest ID
// - Duplicates go into the alarm list
// - Newest fault overwrites latest code and ID
// - Fresh detection clears old fault status
// - Clear command clears faults, keeps slave IDs
// - Default IDs 767/255 mean unset
// - Unset sets alarm, code 0191, latest ID
// - Unset IDs listed and counted
// - No unset report after power loss/reset
// - Auto update polls status and sensors periodically
// - Individual access uses direction and target
// - Batch read fetches all slaves' parameters
// - Batch write sends all slaves' parameters
// - Parameter kinds limited to allowed methods
// - Bit rate frozen during parameter transfers
// - Clearing empties flag, code, ID, count, list
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module sifd_top #(
   parameter int AUTO_CYC = sifd_pkg::AUTO_UPD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic net_pwr_ok_i,
   input wire logic det_valid_i,
   input wire logic [9:0] det_id_i,
   input wire logic det_done_i,
   output logic det_req_o,
   input wire logic param_done_i,
   output logic param_req_o,
   output logic [1:0] param_op_o,
   output logic [9:0] param_tgt_o,
   output logic auto_upd_o,
   output logic [3:0] bit_rate_o,
   output logic slave_alarm_o
);
   function automatic logic [8:0] id_slot(input logic [9:0] id);
      id_slot = {id[9], id[7:0]};
   endfunction

   function automatic logic is_unset(input logic [9:0] id);
      is_unset = (id == sifd_pkg::DEF_IN_ID) || (id == sifd_pkg::DEF_OUT_ID);
   endfunction

   logic pwr_s1;
   logic pwr_s2;
   logic [31:0] next_prdata;
   logic next_err;
   logic [13:0] idx;
   logic wr;
   logic det_go;
   logic fault_flag_clear_cmd;
   logic auto_en;
   logic [3:0] rate_req;
   logic par_dir;
   logic [9:0] par_tgt;
   logic par_done;
   sifd_pkg::sifd_det_t det_st;
   sifd_pkg::sifd_par_t par_st;
   logic [511:0] seen;
   logic [511:0] listed;
   logic [15:0] alarm_list [sifd_pkg::LIST_DEPTH];
   logic [7:0] alarm_id_count;
   logic [15:0] latest_fault_code;
   logic [15:0] latest_fault_id;
   logic [31:0] auto_cnt;
   logic ev;
   logic ev_unset;
   logic ev_dup;
   logic [8:0] slot;

   // Network power is asynchronous to the clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwr_s1 <= 1'b0;
         pwr_s2 <= 1'b0;
      end else begin
         pwr_s1 <= net_pwr_ok_i;
         pwr_s2 <= pwr_s1;
      end
   end

   assign idx = paddr_i[15:2];
   assign wr = psel_i && penable_i && pwrite_i && pready_o;
   assign det_go = wr && (idx == sifd_pkg::IDX_CTRL) && pwdata_i[sifd_pkg::CTRL_DET_BIT]
                   && (det_st == sifd_pkg::DET_IDLE);
   assign slot = id_slot(det_id_i);
   assign ev = (det_st == sifd_pkg::DET_SCAN) && det_valid_i;
   assign ev_unset = ev && is_unset(det_id_i);
   assign ev_dup = ev && !is_unset(det_id_i) && seen[slot];

   // Read data is prepared in the setup cycle so the access phase needs no wait
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (idx >= sifd_pkg::IDX_LIST_FIRST && idx <= sifd_pkg::IDX_LIST_LAST) begin
         next_prdata[15:0] = alarm_list[7'(idx - sifd_pkg::IDX_LIST_FIRST)];
      end else begin
         case (idx)
            sifd_pkg::IDX_ALARM_CNT: next_prdata[7:0] = alarm_id_count;
            sifd_pkg::IDX_FAULT_CODE: next_prdata[15:0] = latest_fault_code;
            sifd_pkg::IDX_FAULT_ID: next_prdata[15:0] = latest_fault_id;
            sifd_pkg::IDX_CTRL: begin
               next_prdata[sifd_pkg::CTRL_CLR_BIT] = fault_flag_clear_cmd;
               next_prdata[sifd_pkg::CTRL_AUTO_BIT] = auto_en;
               next_prdata[sifd_pkg::CTRL_RATE_LSB +: 4] = rate_req;
            end
            sifd_pkg::IDX_STATUS: begin
               next_prdata[sifd_pkg::STAT_DET_BIT] = (det_st == sifd_pkg::DET_SCAN);
               next_prdata[sifd_pkg::STAT_BUSY_BIT] = (par_st == sifd_pkg::PAR_BUSY);
               next_prdata[sifd_pkg::STAT_ALARM_BIT] = slave_alarm_o;
               next_prdata[sifd_pkg::STAT_DONE_BIT] = par_done;
            end
            sifd_pkg::IDX_PAR_CMD: next_prdata = 32'h0000_0000;
            sifd_pkg::IDX_PAR_SET: next_prdata[0] = par_dir;
            sifd_pkg::IDX_PAR_TGT: next_prdata[9:0] = par_tgt;
            default: next_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
         pready_o <= 1'b0;
      end else begin
         pready_o <= 1'b1;
         if (psel_i && !penable_i) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
            pslverr_o <= next_err;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fault_flag_clear_cmd <= 1'b0;
         auto_en <= 1'b0;
         rate_req <= sifd_pkg::RATE_RST;
         par_dir <= 1'b0;
         par_tgt <= 10'h000;
      end else if (wr) begin
         if (idx == sifd_pkg::IDX_CTRL) begin
            fault_flag_clear_cmd <= pwdata_i[sifd_pkg::CTRL_CLR_BIT];
            auto_en <= pwdata_i[sifd_pkg::CTRL_AUTO_BIT];
            rate_req <= pwdata_i[sifd_pkg::CTRL_RATE_LSB +: 4];
         end
         if (idx == sifd_pkg::IDX_PAR_SET) begin
            par_dir <= pwdata_i[0];
         end
         if (idx == sifd_pkg::IDX_PAR_TGT) begin
            par_tgt <= pwdata_i[9:0];
         end
      end
   end

   // Address detection sequencing
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         det_st <= sifd_pkg::DET_IDLE;
         det_req_o <= 1'b0;
      end else begin
         det_req_o <= det_go;
         case (det_st)
            sifd_pkg::DET_IDLE: if (det_go) det_st <= sifd_pkg::DET_SCAN;
            sifd_pkg::DET_SCAN: if (det_done_i || !pwr_s2) det_st <= sifd_pkg::DET_IDLE;
            default: det_st <= sifd_pkg::DET_IDLE;
         endcase
      end
   end

   // IDs seen during the current detection pass
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seen <= '0;
      end else if (det_go || !pwr_s2) begin
         seen <= '0;
      end else if (ev) begin
         seen[slot] <= 1'b1;
      end
   end

   // Fault record; a new event wins over the clear command in the same cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         listed <= '0;
         alarm_id_count <= 8'h00;
         latest_fault_code <= sifd_pkg::FC_NONE;
         latest_fault_id <= 16'h0000;
         slave_alarm_o <= 1'b0;
         for (int i = 0; i < sifd_pkg::LIST_DEPTH; i++) alarm_list[i] <= 16'h0000;
      end else if (!pwr_s2 || det_go) begin
         listed <= '0;
         alarm_id_count <= 8'h00;
         latest_fault_code <= sifd_pkg::FC_NONE;
         latest_fault_id <= 16'h0000;
         slave_alarm_o <= 1'b0;
         for (int i = 0; i < sifd_pkg::LIST_DEPTH; i++) alarm_list[i] <= 16'h0000;
      end else if (ev_unset || ev_dup) begin
         slave_alarm_o <= 1'b1;
         latest_fault_code <= ev_unset ? sifd_pkg::FC_UNSET : sifd_pkg::FC_DUP;
         latest_fault_id <= {6'h00, det_id_i};
         // Repeat offenders share one list entry
         if (!listed[slot] && alarm_id_count != sifd_pkg::LIST_FULL) begin
            listed[slot] <= 1'b1;
            alarm_list[alarm_id_count[6:0]] <= {6'h00, det_id_i};
            alarm_id_count <= alarm_id_count + 8'h01;
         end
      end else if (fault_flag_clear_cmd) begin
         listed <= '0;
         alarm_id_count <= 8'h00;
         latest_fault_code <= sifd_pkg::FC_NONE;
         latest_fault_id <= 16'h0000;
         slave_alarm_o <= 1'b0;
         for (int i = 0; i < sifd_pkg::LIST_DEPTH; i++) alarm_list[i] <= 16'h0000;
      end
   end

   // Parameter transfers: one at a time, completion flag low while busy
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         par_st <= sifd_pkg::PAR_IDLE;
         param_req_o <= 1'b0;
         param_op_o <= sifd_pkg::OP_ACC_RD;
         param_tgt_o <= 10'h000;
         par_done <= 1'b1;
      end else begin
         case (par_st)
            sifd_pkg::PAR_IDLE: begin
               if (wr && idx == sifd_pkg::IDX_PAR_CMD && (|pwdata_i[2:0])) begin
                  par_st <= sifd_pkg::PAR_BUSY;
                  param_req_o <= 1'b1;
                  par_done <= 1'b0;
                  if (pwdata_i[sifd_pkg::PCMD_ACC_BIT]) begin
                     param_op_o <= par_dir ? sifd_pkg::OP_ACC_WR : sifd_pkg::OP_ACC_RD;
                     param_tgt_o <= par_tgt;
                  end else if (pwdata_i[sifd_pkg::PCMD_BRD_BIT]) begin
                     param_op_o <= sifd_pkg::OP_BAT_RD;
                  end else begin
                     // Writes carry device parameters only; ID and status stay read-only
                     param_op_o <= sifd_pkg::OP_BAT_WR;
                  end
               end
            end
            sifd_pkg::PAR_BUSY: begin
               if (param_done_i) begin
                  par_st <= sifd_pkg::PAR_IDLE;
                  param_req_o <= 1'b0;
                  par_done <= 1'b1;
               end
            end
            default: par_st <= sifd_pkg::PAR_IDLE;
         endcase
      end
   end

   // A new rate only takes effect between transfers, never mid-transfer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_rate_o <= sifd_pkg::RATE_RST;
      end else if (par_st == sifd_pkg::PAR_IDLE) begin
         bit_rate_o <= rate_req;
      end
   end

   // Automatic update tick for status and sensor values, no host action needed
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         auto_cnt <= 32'h0000_0000;
         auto_upd_o <= 1'b0;
      end else begin
         auto_upd_o <= 1'b0;
         if (!auto_en) begin
            auto_cnt <= 32'h0000_0000;
         end else if (auto_cnt == 32'(AUTO_CYC - 1)) begin
            auto_cnt <= 32'h0000_0000;
            auto_upd_o <= 1'b1;
         end else begin
            auto_cnt <= auto_cnt + 32'h0000_0001;
         end
      end
   end

   property p_dup_code;
      @(posedge clk_i) disable iff (!rst_b_i)
      ev_dup && pwr_s2 && !det_go |=> slave_alarm_o && latest_fault_code == sifd_pkg::FC_DUP
         && latest_fault_id == {6'h00, $past(det_id_i)};
   endproperty
   a_dup_code: assert property (p_dup_code) else $error("duplicate not reported");

   property p_unset_code;
      @(posedge clk_i) disable iff (!rst_b_i)
      ev_unset && pwr_s2 && !det_go |=> slave_alarm_o && latest_fault_code == sifd_pkg::FC_UNSET;
   endproperty
   a_unset_code: assert property (p_unset_code) else $error("unset ID not reported");

   property p_once;
      @(posedge clk_i) disable iff (!rst_b_i)
      ev && listed[slot] && pwr_s2 && !det_go |=> $stable(alarm_id_count);
   endproperty
   a_once: assert property (p_once) else $error("ID counted twice");

   property p_hold;
      @(posedge clk_i) disable iff (!rst_b_i)
      slave_alarm_o && !fault_flag_clear_cmd && !det_go && pwr_s2 |=> slave_alarm_o;
   endproperty
   a_hold: assert property (p_hold) else $error("alarm dropped");

   property p_clear;
      @(posedge clk_i) disable iff (!rst_b_i)
      fault_flag_clear_cmd && !ev_dup && !ev_unset |=> !slave_alarm_o && alarm_id_count == 8'h00
         && latest_fault_code == sifd_pkg::FC_NONE && latest_fault_id == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) else $error("clear incomplete");

   property p_restart;
      @(posedge clk_i) disable iff (!rst_b_i)
      det_go |=> !slave_alarm_o && alarm_id_count == 8'h00 && det_req_o;
   endproperty
   a_restart: assert property (p_restart) else $error("detection did not clear");

   property p_pwr;
      @(posedge clk_i) disable iff (!rst_b_i)
      !pwr_s2 |=> !slave_alarm_o && seen == '0;
   endproperty
   a_pwr: assert property (p_pwr) else $error("status survived power loss");

   property p_rate;
      @(posedge clk_i) disable iff (!rst_b_i)
      par_st == sifd_pkg::PAR_BUSY |=> $stable(bit_rate_o);
   endproperty
   a_rate: assert property (p_rate) else $error("rate changed in transfer");

   property p_req;
      @(posedge clk_i) disable iff (!rst_b_i)
      par_st == sifd_pkg::PAR_IDLE && wr && idx == sifd_pkg::IDX_PAR_CMD && pwdata_i[0]
         |=> param_req_o && !par_done && param_tgt_o == $past(par_tgt);
   endproperty
   a_req: assert property (p_req) else $error("access not started");

   property p_default_id;
      @(posedge clk_i) disable iff (!rst_b_i)
      ev && pwr_s2 && (det_id_i == sifd_pkg::DEF_IN_ID || det_id_i == sifd_pkg::DEF_OUT_ID)
         |=> slave_alarm_o && latest_fault_code == sifd_pkg::FC_UNSET;
   endproperty
   a_default_id: assert property (p_default_id) else $error("default ID not treated as unset");

   property p_list_add;
      @(posedge clk_i) disable iff (!rst_b_i)
      (ev_dup || ev_unset) && !listed[slot] && alarm_id_count != sifd_pkg::LIST_FULL && pwr_s2
         |=> alarm_id_count == $past(alarm_id_count) + 8'h01;
   endproperty
   a_list_add: assert property (p_list_add) else $error("new alarm ID not counted");

   property p_batch_rd;
      @(posedge clk_i) disable iff (!rst_b_i)
      par_st == sifd_pkg::PAR_IDLE && wr && idx == sifd_pkg::IDX_PAR_CMD && pwdata_i[2:0] == 3'b010
         |=> param_req_o && param_op_o == sifd_pkg::OP_BAT_RD;
   endproperty
   a_batch_rd: assert property (p_batch_rd) else $error("batch read not started");

   property p_batch_wr;
      @(posedge clk_i) disable iff (!rst_b_i)
      par_st == sifd_pkg::PAR_IDLE && wr && idx == sifd_pkg::IDX_PAR_CMD && pwdata_i[2:0] == 3'b100
         |=> param_req_o && param_op_o == sifd_pkg::OP_BAT_WR;
   endproperty
   a_batch_wr: assert property (p_batch_wr) else $error("batch write not started");

endmodule // sifd_top

// file: test/sifd_link_model.sv
// Network-side model: slaves answering address detection and parameter transfers
`timescale 1ns/1ps
module sifd_link_model (
   input wire logic clk_i,
   input wire logic det_req_i,
   input wire logic param_req_i,
   input wire logic [3:0][9:0] ids_i,
   input wire logic [2:0] n_ids_i,
   input wire logic [7:0] lat_i,
   output logic det_valid_o,
   output logic [9:0] det_id_o,
   output logic det_done_o,
   output logic param_done_o
);
   int i;
   initial begin
      det_valid_o = 1'b0;
      det_id_o = 10'h155;
      det_done_o = 1'b0;
      param_done_o = 1'b0;
   end
   // Every slave reports its own identifier, defaults and clashes included
   always begin
      @(posedge clk_i);
      if (det_req_i === 1'b1) begin
         for (i = 0; i < int'(n_ids_i); i++) begin
            det_valid_o <= 1'b1;
            det_id_o <= ids_i[i];
            @(posedge clk_i);
         end
         det_valid_o <= 1'b0;
         // Idle data line shows the inverse so a stale value is never mistaken for an ID
         det_id_o <= ~det_id_o;
         det_done_o <= 1'b1;
         @(posedge clk_i);
         det_done_o <= 1'b0;
      end
   end
   // Transfer latency comes from the bench, which gives every transfer a slow link of 20 to 39 cycles
   always begin
      @(posedge clk_i);
      if (param_req_i === 1'b1) begin
         repeat (int'(lat_i)) @(posedge clk_i);
         param_done_o <= 1'b1;
         @(posedge clk_i);
         param_done_o <= 1'b0;
         @(posedge clk_i);
      end
   end
endmodule // sifd_link_model

// file: test/testbench.sv
// Self-checking bench for the slave ID fault detector
`timescale 1ns/1ps
module testbench;
   localparam int AUTO = 8;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic net_pwr = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, det_valid, det_done, det_req, param_done, param_req, auto_upd, alarm;
   logic [9:0] det_id, param_tgt, r;
   logic [1:0] param_op;
   logic [3:0] bit_rate;
   logic [3:0][9:0] ids = '0;
   logic [2:0] n_ids = 3'h0;
   logic [7:0] lat = 8'h02;
   logic [31:0] rd;
   logic err;
   logic [63:0] v;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int k, cnt;

   always #50 clk_i = ~clk_i;

   sifd_top #(.AUTO_CYC(AUTO)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .net_pwr_ok_i(net_pwr), .det_valid_i(det_valid), .det_id_i(det_id),
      .det_done_i(det_done), .det_req_o(det_req), .param_done_i(param_done), .param_req_o(param_req),
      .param_op_o(param_op), .param_tgt_o(param_tgt), .auto_upd_o(auto_upd), .bit_rate_o(bit_rate),
      .slave_alarm_o(alarm));

   sifd_link_model link_u (.clk_i(clk_i), .det_req_i(det_req), .param_req_i(param_req), .ids_i(ids),
      .n_ids_i(n_ids), .lat_i(lat), .det_valid_o(det_valid), .det_id_o(det_id), .det_done_o(det_done),
      .param_done_o(param_done));

   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [63:0] exp_f(input logic a, input logic [15:0] c, input logic [15:0] i,
      input logic [15:0] n);
      return {15'h0000, a, c, i, n};
   endfunction

   task automatic rd_fault(output logic [63:0] f);
      f = '0;
      f[48] = alarm;
      apb(1'b0, sifd_pkg::IDX_FAULT_CODE, 32'h0);
      f[47:32] = rd[15:0];
      apb(1'b0, sifd_pkg::IDX_FAULT_ID, 32'h0);
      f[31:16] = rd[15:0];
      apb(1'b0, sifd_pkg::IDX_ALARM_CNT, 32'h0);
      f[15:0] = rd[15:0];
   endtask

   // Runs one detection pass and polls until the status shows it has ended
   task automatic detect(input logic [9:0] a, input logic [9:0] b, input logic [9:0] c);
      ids <= {10'h000, c, b, a};
      n_ids <= 3'h3;
      apb(1'b1, sifd_pkg::IDX_CTRL, 32'h2);
      do begin
         apb(1'b0, sifd_pkg::IDX_STATUS, 32'h0);
      end while (rd[sifd_pkg::STAT_DET_BIT] !== 1'b0);
   endtask

   initial begin
      void'($urandom(50));
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_fault(v);
      chk("reset_state", v, exp_f(1'b0, sifd_pkg::FC_NONE, 16'h0, 16'h0));
      apb(1'b1, sifd_pkg::IDX_ALARM_CNT, 32'h5);
      apb(1'b0, sifd_pkg::IDX_ALARM_CNT, 32'h0);
      chk("count_ro", rd, 64'h0);
      apb(1'b0, 14'h3000, 32'h0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      $display("test registers done");
      r = 10'($urandom % 255);
      detect(r, r | 10'h200, r);
      rd_fault(v);
      chk("dup", v, exp_f(1'b1, sifd_pkg::FC_DUP, 16'(r), 16'h1));
      apb(1'b0, sifd_pkg::IDX_LIST_FIRST, 32'h0);
      chk("dup_list", rd, 64'(r));
      apb(1'b0, 14'(sifd_pkg::IDX_LIST_FIRST + 14'h1), 32'h0);
      chk("dup_once", rd, 64'h0);
      repeat (20) @(posedge clk_i);
      chk("alarm_hold", alarm, 64'h1);
      detect(sifd_pkg::DEF_IN_ID, sifd_pkg::DEF_OUT_ID, sifd_pkg::DEF_IN_ID);
      rd_fault(v);
      chk("unset", v, exp_f(1'b1, sifd_pkg::FC_UNSET, 16'h2FF, 16'h2));
      apb(1'b0, 14'(sifd_pkg::IDX_LIST_FIRST + 14'h1), 32'h0);
      chk("unset_list", rd, 64'h0FF);
      detect(r, r, sifd_pkg::DEF_OUT_ID);
      rd_fault(v);
      chk("latest_unset", v, exp_f(1'b1, sifd_pkg::FC_UNSET, 16'h0FF, 16'h2));
      detect(sifd_pkg::DEF_OUT_ID, r, r);
      rd_fault(v);
      chk("latest_dup", v, exp_f(1'b1, sifd_pkg::FC_DUP, 16'(r), 16'h2));
      detect(10'h001, 10'h002, 10'h203);
      rd_fault(v);
      chk("redetect", v, exp_f(1'b0, sifd_pkg::FC_NONE, 16'h0, 16'h0));
      $display("test detection done");
      detect(r, r, sifd_pkg::DEF_IN_ID);
      apb(1'b1, sifd_pkg::IDX_CTRL, 32'h1);
      apb(1'b1, sifd_pkg::IDX_CTRL, 32'h0);
      rd_fault(v);
      chk("clear_cmd", v, exp_f(1'b0, sifd_pkg::FC_NONE, 16'h0, 16'h0));
      apb(1'b0, sifd_pkg::IDX_LIST_FIRST, 32'h0);
      chk("clear_list", rd, 64'h0);
      detect(sifd_pkg::DEF_IN_ID, r, r);
      net_pwr <= 1'b0;
      repeat (4) @(posedge clk_i);
      net_pwr <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd_fault(v);
      chk("power_loss", v, exp_f(1'b0, sifd_pkg::FC_NONE, 16'h0, 16'h0));
      $display("test clearing done");
      for (k = 0; k < 4; k++) begin
         r = 10'h200 | 10'($urandom % 256);
         lat <= 8'(20 + $urandom % 20);
         apb(1'b1, sifd_pkg::IDX_PAR_SET, 32'(k == 1));
         apb(1'b1, sifd_pkg::IDX_PAR_TGT, 32'(r));
         apb(1'b1, sifd_pkg::IDX_PAR_CMD, (k < 2) ? 32'h1 : 32'(k * 2 - 2));
         @(posedge clk_i);
         #1;
         chk("param_op", {param_req, param_op}, {1'b1, 2'(k)});
         if (k < 2) chk("param_tgt", param_tgt, 64'(r));
         apb(1'b1, sifd_pkg::IDX_CTRL, 32'((k + 1) << 4));
         // Two edges let a rate that leaks through the busy guard reach the output
         repeat (2) @(posedge clk_i);
         chk("rate_hold", bit_rate, 64'(k));
         while (param_req === 1'b1) @(posedge clk_i);
         apb(1'b0, sifd_pkg::IDX_STATUS, 32'h0);
         chk("param_done", {rd[sifd_pkg::STAT_DONE_BIT], bit_rate}, {1'b1, 4'(k + 1)});
      end
      $display("test parameters done");
      apb(1'b1, sifd_pkg::IDX_CTRL, 32'h4);
      for (k = 0; k < 2; k++) begin
         repeat (4) @(posedge clk_i);
         cnt = 0;
         repeat (40) begin
            @(posedge clk_i);
            if (auto_upd === 1'b1) cnt++;
         end
         chk("auto_update", 64'(cnt), (k == 0) ? 64'h5 : 64'h0);
         apb(1'b1, sifd_pkg::IDX_CTRL, 32'h0);
      end
      $display("test auto update done");
      wrap_up();
   end
endmodule // testbench
